//--- pkg/sbfcd_pkg.sv
// Package for the serial boot flash command decoder
package sbfcd_pkg;

   // ----------------------------------------
   // Opcodes
   // ----------------------------------------
   localparam logic [7:0] OP_PAGE_READ   = 8'hFF;
   localparam logic [7:0] OP_PAGE_PROG   = 8'h41;
   localparam logic [7:0] OP_BLOCK_ERASE = 8'h20;
   localparam logic [7:0] OP_ERASE_ALL   = 8'hA7;
   localparam logic [7:0] OP_STAT_READ   = 8'h70;
   localparam logic [7:0] OP_STAT_CLEAR  = 8'h50;
   localparam logic [7:0] OP_LOCK_READ   = 8'h71;
   localparam logic [7:0] OP_LOCK_PROG   = 8'h77;
   localparam logic [7:0] OP_LOCK_EN     = 8'h7A;
   localparam logic [7:0] OP_LOCK_DIS    = 8'h75;
   localparam logic [7:0] OP_ID_CHECK    = 8'hF5;
   localparam logic [7:0] OP_DOWNLOAD    = 8'hFA;
   localparam logic [7:0] OP_VERSION     = 8'hFB;
   localparam logic [7:0] OP_BOOT_READ   = 8'hFC;
   localparam logic [7:0] OP_CHECK_READ  = 8'hFD;
   localparam logic [7:0] CONFIRM_BYTE   = 8'hD0;

   // ----------------------------------------
   // Sequence lengths and fields
   // ----------------------------------------
   localparam logic [8:0] LAST_PAGE_BYTE = 9'h103;   // 259th byte, index 258
   localparam logic [8:0] LAST_VER_BYTE  = 9'h009;   // 9th byte
   localparam logic [8:0] ID_LAST_BYTE   = 9'h00B;   // 5 header bytes + 7 id bytes
   localparam int         ID_LEN         = 7;
   localparam int         ERR_LO         = 3;
   localparam int         ERR_HI         = 5;
   localparam logic [7:0] SR_RESET       = 8'h80;
   localparam logic [7:0] SR1_RESET      = 8'h00;
   localparam logic [7:0] VERSION_CHAR   = 8'h56;    // Arbitrary value
   localparam logic [55:0] ID_CODE       = 56'h0102_0304_0506_07;  // Arbitrary value

   typedef struct packed
   {
      logic clk;
      logic rxd;
   } sbfcd_link_in_t;

   typedef struct packed
   {
      logic [7:0]  data;
      logic [23:0] addr;
   } sbfcd_mem_req_t;

endpackage

//--- core/sbfcd_decoder.sv
// Serial boot flash command decoder, device side
`timescale 1ns/100ps
module sbfcd_decoder
(
   input  wire logic        clk,                // 25 MHz
   input  wire logic        arst_n,             // Async reset
   input  wire logic        transfer_clock_input, // Link clock pin
   input  wire logic        serial_receive_line,  // Link data in
   output logic             serial_transmit_line, // Link data out
   output logic             busy_handshake_output,// Busy to programmer
   input  wire logic        flash_blank,        // Array fully blank
   input  wire logic [7:0]  mem_rdata,          // Page or boot data
   input  wire logic        lock_status,        // Lock bit of block
   input  wire logic [7:0]  check_data_lo,      // Check sum low
   input  wire logic [7:0]  check_data_hi,      // Check sum high
   input  wire logic [2:0]  err_set,            // Error events, bits 3..5
   output sbfcd_pkg::sbfcd_mem_req_t mem_req,   // Read address request
   output logic             op_strobe,          // One pulse per erase, lock or status clear command
   output logic [7:0]       op_code,            // Operation opcode
   output logic             id_ok               // Identity verified
);

   typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_XFER = 2'b01, ST_DONE = 2'b10} sbfcd_st_t;

   // ----------------------------------------
   // Pin synchronisers and edges
   // ----------------------------------------
   sbfcd_pkg::sbfcd_link_in_t s1_r, s2_r;
   logic        clk_d_r;
   logic        rise, fall;

   always_ff @(posedge clk or negedge arst_n)
      if (!arst_n)
      begin
         // Idle level of both pins, so no false edge follows reset
         s1_r    <= '1;
         s2_r    <= '1;
         clk_d_r <= 1'b1;
      end
      else
      begin
         s1_r    <= {transfer_clock_input, serial_receive_line};
         s2_r    <= s1_r;
         clk_d_r <= s2_r.clk;
      end

   assign rise = s2_r.clk & ~clk_d_r;
   assign fall = ~s2_r.clk & clk_d_r;

   // ----------------------------------------
   // Shifter
   // ----------------------------------------
   logic [7:0] rx_sh_r, tx_sh_r;
   logic [2:0] bit_r;
   logic [8:0] byte_idx_r;
   logic [7:0] cmd_r;
   logic [7:0] addr_mid_r, addr_hi_r;
   logic [7:0] page_off_r;
   logic       byte_done;
   logic [7:0] rx_byte;
   sbfcd_st_t  st_r;
   logic [7:0] sr_r, sr1_r;
   logic [55:0] id_sh_r;
   logic       allowed;
   logic [7:0] tx_next;

   assign rx_byte   = {s2_r.rxd, rx_sh_r[7:1]};
   assign byte_done = rise && bit_r == 3'd7;

   always_ff @(posedge clk or negedge arst_n)
      if (!arst_n)
      begin
         rx_sh_r <= 8'h00;
         bit_r   <= 3'd0;
      end
      else if (rise)
      begin
         rx_sh_r <= rx_byte;
         bit_r   <= bit_r + 3'd1;
      end

   function automatic logic cmd_free(input logic [7:0] c);
      return c == sbfcd_pkg::OP_STAT_READ || c == sbfcd_pkg::OP_ID_CHECK ||
             c == sbfcd_pkg::OP_VERSION;
   endfunction

   assign allowed = flash_blank | id_ok | cmd_free(rx_byte);

   // ----------------------------------------
   // Command sequencing
   // ----------------------------------------
   always_ff @(posedge clk or negedge arst_n)
      if (!arst_n)
      begin
         byte_idx_r <= 9'd0;
         cmd_r      <= 8'h00;
         addr_mid_r <= 8'h00;
         addr_hi_r  <= 8'h00;
         page_off_r <= 8'h00;
         op_strobe  <= 1'b0;
         op_code    <= 8'h00;
      end
      else
      begin
         op_strobe <= 1'b0;
         if (byte_done)
         begin
            byte_idx_r <= byte_idx_r + 9'd1;
            if (byte_idx_r == 9'd0)
            begin
               cmd_r      <= allowed ? rx_byte : 8'h00;
               page_off_r <= 8'h00;
               if (allowed && (rx_byte == sbfcd_pkg::OP_LOCK_EN ||
                  rx_byte == sbfcd_pkg::OP_LOCK_DIS || rx_byte == sbfcd_pkg::OP_STAT_CLEAR))
               begin
                  op_strobe  <= 1'b1;
                  op_code    <= rx_byte;
                  byte_idx_r <= 9'd0;
               end
               if (!allowed)
                  byte_idx_r <= 9'd0;
            end
            else if (byte_idx_r == 9'd1)
               addr_mid_r <= rx_byte;
            else if (byte_idx_r == 9'd2)
               addr_hi_r <= rx_byte;
            if (byte_idx_r >= 9'd3)
               page_off_r <= page_off_r + 8'd1;
            if (byte_idx_r == 9'd1 && cmd_r == sbfcd_pkg::OP_ERASE_ALL &&
                rx_byte == sbfcd_pkg::CONFIRM_BYTE)
            begin
               op_strobe <= 1'b1;
               op_code   <= cmd_r;
            end
            if (byte_idx_r == 9'd3 && rx_byte == sbfcd_pkg::CONFIRM_BYTE &&
                (cmd_r == sbfcd_pkg::OP_BLOCK_ERASE || cmd_r == sbfcd_pkg::OP_LOCK_PROG))
            begin
               op_strobe <= 1'b1;
               op_code   <= cmd_r;
            end
            if ((byte_idx_r + 9'd1 == sbfcd_pkg::LAST_PAGE_BYTE &&
                 (cmd_r == sbfcd_pkg::OP_PAGE_READ || cmd_r == sbfcd_pkg::OP_BOOT_READ ||
                  cmd_r == sbfcd_pkg::OP_PAGE_PROG)) ||
                (byte_idx_r + 9'd1 == sbfcd_pkg::LAST_VER_BYTE && cmd_r == sbfcd_pkg::OP_VERSION) ||
                (byte_idx_r == 9'd2 && (cmd_r == sbfcd_pkg::OP_STAT_READ ||
                  cmd_r == sbfcd_pkg::OP_CHECK_READ)) ||
                (byte_idx_r == 9'd3 && (cmd_r == sbfcd_pkg::OP_LOCK_READ ||
                  cmd_r == sbfcd_pkg::OP_BLOCK_ERASE || cmd_r == sbfcd_pkg::OP_LOCK_PROG)) ||
                (byte_idx_r == 9'd1 && cmd_r == sbfcd_pkg::OP_ERASE_ALL) ||
                (byte_idx_r == sbfcd_pkg::ID_LAST_BYTE && cmd_r == sbfcd_pkg::OP_ID_CHECK) ||
                cmd_r == 8'h00 && byte_idx_r != 9'd0)
               byte_idx_r <= 9'd0;
         end
      end

   // Download payload length is programmer-defined; it stays open until the 9-bit byte index wraps to 0 after 512 bytes
   assign mem_req = '{data: 8'h00, addr: {addr_hi_r, addr_mid_r, page_off_r}};

   // ----------------------------------------
   // Identity check
   // ----------------------------------------
   always_ff @(posedge clk or negedge arst_n)
      if (!arst_n)
      begin
         id_sh_r <= '0;
         id_ok   <= 1'b0;
      end
      else if (byte_done && cmd_r == sbfcd_pkg::OP_ID_CHECK && byte_idx_r >= 9'd5)
      begin
         id_sh_r <= {id_sh_r[47:0], rx_byte};
         if (byte_idx_r == sbfcd_pkg::ID_LAST_BYTE)
            id_ok <= {id_sh_r[47:0], rx_byte} == sbfcd_pkg::ID_CODE;
      end

   // ----------------------------------------
   // Status registers
   // ----------------------------------------
   always_ff @(posedge clk or negedge arst_n)
      if (!arst_n)
      begin
         sr_r  <= sbfcd_pkg::SR_RESET;
         sr1_r <= sbfcd_pkg::SR1_RESET;
      end
      else
      begin
         if (op_strobe && op_code == sbfcd_pkg::OP_STAT_CLEAR)
            sr_r[sbfcd_pkg::ERR_HI:sbfcd_pkg::ERR_LO] <= err_set;
         else
            sr_r[sbfcd_pkg::ERR_HI:sbfcd_pkg::ERR_LO] <=
               sr_r[sbfcd_pkg::ERR_HI:sbfcd_pkg::ERR_LO] | err_set;
         sr1_r <= {6'h00, id_ok, flash_blank};
      end

   // ----------------------------------------
   // Transmit
   // ----------------------------------------
   always_comb
   begin
      tx_next = 8'hFF;
      case (cmd_r)
         sbfcd_pkg::OP_PAGE_READ, sbfcd_pkg::OP_BOOT_READ:
            if (byte_idx_r >= 9'd3) tx_next = mem_rdata;
         sbfcd_pkg::OP_STAT_READ:
            tx_next = (byte_idx_r == 9'd1) ? sr_r : sr1_r;
         sbfcd_pkg::OP_LOCK_READ:
            if (byte_idx_r == 9'd3) tx_next = {1'b0, lock_status, 6'h00};
         sbfcd_pkg::OP_VERSION:
            tx_next = sbfcd_pkg::VERSION_CHAR;
         sbfcd_pkg::OP_CHECK_READ:
            tx_next = (byte_idx_r == 9'd1) ? check_data_lo : check_data_hi;
         default:
            tx_next = 8'hFF;
      endcase
   end

   logic load_pend_r;

   always_ff @(posedge clk or negedge arst_n)
      if (!arst_n)
      begin
         tx_sh_r              <= 8'hFF;
         serial_transmit_line <= 1'b1;
         load_pend_r          <= 1'b0;
      end
      else
      begin
         load_pend_r <= byte_done;
         // Load one cycle late so the byte index and memory data are settled
         if (load_pend_r)
            tx_sh_r <= tx_next;
         else if (fall)
         begin
            serial_transmit_line <= tx_sh_r[0];
            tx_sh_r              <= {1'b1, tx_sh_r[7:1]};
         end
      end

   // ----------------------------------------
   // Busy handshake
   // ----------------------------------------
   always_ff @(posedge clk or negedge arst_n)
      if (!arst_n)
      begin
         st_r                  <= ST_IDLE;
         busy_handshake_output <= 1'b0;
      end
      else
         case (st_r)
            ST_IDLE:
               if (fall)
               begin
                  st_r                  <= ST_XFER;
                  busy_handshake_output <= 1'b1;
               end
            ST_XFER:
               if (load_pend_r)
                  st_r <= ST_DONE;
            ST_DONE:
            begin
               st_r                  <= ST_IDLE;
               busy_handshake_output <= 1'b0;
            end
            default:
               st_r <= ST_IDLE;
         endcase

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   property p_busy_release;
      @(posedge clk) disable iff (!arst_n)
      (st_r == ST_DONE) |=> !busy_handshake_output;
   endproperty
   a_busy_release: assert property (p_busy_release) else $error("busy not released");

   property p_clear_err;
      @(posedge clk) disable iff (!arst_n)
      (op_strobe && op_code == sbfcd_pkg::OP_STAT_CLEAR && err_set == 3'b000)
         |=> sr_r[5:3] == 3'b000;
   endproperty
   a_clear_err: assert property (p_clear_err) else $error("error bits not cleared");

   property p_reject;
      @(posedge clk) disable iff (!arst_n)
      (byte_done && byte_idx_r == 9'd0 && !flash_blank && !id_ok &&
       !cmd_free(rx_byte)) |=> cmd_r == 8'h00;
   endproperty
   a_reject: assert property (p_reject) else $error("locked command taken");

   property p_blank;
      @(posedge clk) disable iff (!arst_n)
      (byte_done && byte_idx_r == 9'd0 && flash_blank) |=> cmd_r == $past(rx_byte);
   endproperty
   a_blank: assert property (p_blank) else $error("blank flash refused command");

   property p_busy_xfer;
      @(posedge clk) disable iff (!arst_n)
      (st_r == ST_XFER) |-> busy_handshake_output;
   endproperty
   a_busy_xfer: assert property (p_busy_xfer) else $error("busy low during transfer");

   property p_erase_all;
      @(posedge clk) disable iff (!arst_n)
      (byte_done && byte_idx_r == 9'd1 && cmd_r == sbfcd_pkg::OP_ERASE_ALL &&
       rx_byte == sbfcd_pkg::CONFIRM_BYTE) |=> op_strobe && op_code == 8'hA7;
   endproperty
   a_erase_all: assert property (p_erase_all) else $error("erase all missed");

   property p_page_end;
      @(posedge clk) disable iff (!arst_n)
      (byte_done && cmd_r == sbfcd_pkg::OP_PAGE_READ && byte_idx_r == 9'd258)
         |=> byte_idx_r == 9'd0;
   endproperty
   a_page_end: assert property (p_page_end) else $error("page read length wrong");

   property p_version;
      @(posedge clk) disable iff (!arst_n)
      (byte_done && byte_idx_r == 9'd0 && rx_byte == sbfcd_pkg::OP_VERSION)
         |=> cmd_r == sbfcd_pkg::OP_VERSION;
   endproperty
   a_version: assert property (p_version) else $error("version refused");

endmodule

//--- tb/sbfcd_programmer_model.sv
// Model of the external programmer: transfer clock, receive data, paced by busy
`timescale 1ns/100ps
module sbfcd_programmer_model
(
   input  wire logic clk,   // Device clock, bounds the waits
   input  wire logic busy,  // Busy from device
   input  wire logic txd,   // Data from device
   output logic      sclk,  // Transfer clock, idle high
   output logic      rxd    // Data to device
);
   int timeouts = 0;
   initial
   begin
      sclk = 1'b1;
      rxd  = 1'b1;
   end
   task automatic wait_ready();
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 400)
      begin
         @(posedge clk);
         n++;
      end
      if (n >= 400)
         timeouts++;
   endtask
   // lsb first, data out on fall, sample on rise
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      wait_ready();
      #7;
      for (int i = 0; i < 8; i++)
      begin
         sclk  = 1'b0;
         rxd   = tx[i];
         #160;
         sclk  = 1'b1;
         rx[i] = txd;
         #160;
      end
      // Inverse of last bit, so a stale sample never passes
      rxd = ~tx[7];
   endtask
endmodule

//--- tb/tb_serial_boot_flash_command_decoder.sv
// Testbench for the serial boot flash command decoder
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin failures++; \
   $display("wrong value %s exp %h got %h", nm, e, g); end end
module tb_serial_boot_flash_command_decoder;
   logic                      clk, arst_n, flash_blank, lock_status, op_strobe, id_ok;
   logic [7:0]                mem_rdata, chk_lo, chk_hi, op_code, last_op, rx;
   logic [2:0]                err_set;
   logic                      sclk, rxd, txd, busy;
   sbfcd_pkg::sbfcd_mem_req_t mem_req;
   int                        failures = 0;
   int                        checked = 0;
   int                        strobes = 0;
   logic [7:0]                id_hdr [5] = '{8'hF5, 8'h00, 8'h00, 8'h00, 8'h07};

   sbfcd_decoder dut_u (.clk(clk), .arst_n(arst_n), .transfer_clock_input(sclk),
      .serial_receive_line(rxd), .serial_transmit_line(txd), .busy_handshake_output(busy),
      .flash_blank(flash_blank), .mem_rdata(mem_rdata), .lock_status(lock_status),
      .check_data_lo(chk_lo), .check_data_hi(chk_hi), .err_set(err_set),
      .mem_req(mem_req), .op_strobe(op_strobe), .op_code(op_code), .id_ok(id_ok));
   sbfcd_programmer_model pm_u (.clk(clk), .busy(busy), .txd(txd), .sclk(sclk), .rxd(rxd));

   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Memory answers a pattern of its own address
   always @(negedge clk)
      mem_rdata <= mem_req.addr[7:0] ^ mem_req.addr[15:8] ^ 8'hA5;
   always @(posedge clk)
      if (op_strobe === 1'b1)
      begin
         strobes++;
         last_op <= op_code;
      end

   task automatic send(input logic [7:0] b);
      pm_u.xfer(b, rx);
   endtask
   task automatic t_status(input logic [7:0] e1, input logic [7:0] e2);
      send(8'h70);
      send(8'h00);
      `CHK("main status", e1, rx)
      send(8'h00);
      `CHK("second status", e2, rx)
   endtask
   task automatic t_refuse();
      int s;
      s = strobes;
      send(sbfcd_pkg::OP_STAT_CLEAR);
      repeat (10) @(negedge clk);
      `CHK("refused strobes", s, strobes)
   endtask
   task automatic t_version();
      send(sbfcd_pkg::OP_VERSION);
      for (int i = 2; i <= 9; i++)
      begin
         send(8'h00);
         `CHK("version byte", sbfcd_pkg::VERSION_CHAR, rx)
      end
   endtask
   task automatic t_ident(input logic good);
      logic [55:0] id;
      id = sbfcd_pkg::ID_CODE ^ {55'h0, ~good};
      foreach (id_hdr[i])
         send(id_hdr[i]);
      for (int k = 6; k >= 0; k--)
         send(id[k*8 +: 8]);
      repeat (10) @(negedge clk);
      `CHK("id ok", good, id_ok)
   endtask
   task automatic t_clear();
      @(negedge clk);
      flash_blank = 1'b1;
      err_set = 3'b111;
      @(negedge clk);
      err_set = 3'b000;
      t_status(8'hB8, 8'h01);
      send(sbfcd_pkg::OP_STAT_CLEAR);
      repeat (10) @(negedge clk);
      `CHK("clear strobe op", sbfcd_pkg::OP_STAT_CLEAR, last_op)
      `CHK("busy after clear", 1'b0, busy)
      t_status(8'h80, 8'h01);
      flash_blank = 1'b0;
   endtask
   task automatic t_ops();
      logic [7:0] ops [5] = '{8'h7A, 8'h75, 8'hA7, 8'h20, 8'h77};
      int         ext [5] = '{0, 0, 1, 3, 3};
      int         s;
      for (int i = 0; i < 5; i++)
      begin
         s = strobes;
         send(ops[i]);
         if (ext[i] == 3)
         begin
            send(8'h12);
            send(8'h03);
         end
         if (ext[i] > 0)
            send(sbfcd_pkg::CONFIRM_BYTE);
         repeat (10) @(negedge clk);
         `CHK("op strobes", s + 1, strobes)
         `CHK("op code", ops[i], last_op)
      end
   endtask
   task automatic t_lock();
      for (int v = 1; v >= 0; v--)
      begin
         @(negedge clk);
         lock_status = v[0];
         send(sbfcd_pkg::OP_LOCK_READ);
         send(8'h34);
         send(8'h01);
         send(8'h00);
         `CHK("lock bit", v[0], rx[6])
      end
   endtask
   task automatic t_check();
      send(sbfcd_pkg::OP_CHECK_READ);
      send(8'h00);
      `CHK("check low", chk_lo, rx)
      send(8'h00);
      `CHK("check high", chk_hi, rx)
   endtask
   task automatic t_page(input logic [7:0] op, input logic [7:0] mid);
      send(op);
      send(mid);
      send(8'h02);
      for (int k = 0; k < 256; k++)
      begin
         send(8'h00);
         `CHK("page data", k[7:0] ^ mid ^ 8'hA5, rx)
      end
      `CHK("page address", {8'h02, mid}, mem_req.addr[23:8])
      // Sequence must end at byte 259 or this status read is swallowed
      t_status(8'h80, 8'h02);
   endtask

   task automatic conclude();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Whole run is near 40k cycles
   initial
   begin
      #3_000_000;
      failures++;
      conclude();
   end
   initial
   begin
      arst_n = 1'b0;
      flash_blank = 1'b0;
      lock_status = 1'b0;
      err_set = 3'b000;
      chk_lo = 8'h3C;
      chk_hi = 8'hC5;
      repeat (10) @(negedge clk);
      `CHK("idle tx", 1'b1, txd)
      `CHK("idle busy", 1'b0, busy)
      arst_n = 1'b1;
      repeat (4) @(negedge clk);
      t_status(8'h80, 8'h00);
      t_refuse();
      t_version();
      t_ident(1'b0);
      t_clear();
      t_ident(1'b1);
      t_ops();
      t_lock();
      t_check();
      t_page(sbfcd_pkg::OP_PAGE_READ, 8'h12);
      t_page(sbfcd_pkg::OP_BOOT_READ, 8'h5E);
      `CHK("busy waits", 0, pm_u.timeouts)
      conclude();
   end
endmodule
